// ---- core/psrb_top.sv ----
/*
  Peripheral soft reset bank: two software registers on an Avalon-MM slave
  that hold the per-port and per-peripheral reset lines.
  Assumes the capability words arrive as stable inputs synchronous to clk_i
  and that the master keeps each request steady until waitrequest is low.
*/
`default_nettype none
`include "psrb_cfg.svh"

// Functional notes
// - Writes to the port reset register only change bits enabled by capability word four.
// - The port reset register holds eight writable bits, port A at bit 0 to port H at bit 7, zero after reset.
// - Bits 31 to 8 of the port reset register read zero and cannot be written.
// - The peripheral reset register holds the sync serial unit at bit 4 and serial ports 1 and 0 at bits 1 and 0.
// - Bits 11 to 5 and 3 to 2 of the peripheral reset register read zero and cannot be written.
// - The peripheral reset register holds one reset bit for each of the four general counters.
// - The peripheral reset register holds a reset bit for two-wire unit zero.
// - Writes to the peripheral reset register at offset 0x044 only change bits enabled by capability word two.
module psrb_top (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  input wire logic [11:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  input wire logic [31:0] capability_register_two_i,
  input wire logic [31:0] capability_register_four_i,
  output psrb_pkg::psrb_port_rst_s port_rst_o,
  output psrb_pkg::psrb_periph_rst_s periph_rst_o
);

  logic rst_meta_ff;
  logic rst_sync_ff;
  logic ack_ff;
  logic nxt_ack;
  logic [31:0] rdata_ff;
  logic [31:0] nxt_rdata;
  logic req;
  logic accept;
  logic hit_port;
  logic hit_periph;
  logic [31:0] port_q;
  logic [31:0] periph_q;

  // Reset release through two flops so every flop leaves reset on the same
  // edge; the synchroniser runs even while ce_i is low.
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      rst_meta_ff <= 1'b0;
      rst_sync_ff <= 1'b0;
    end
    else
    begin
      rst_meta_ff <= 1'b1;
      rst_sync_ff <= rst_meta_ff;
    end
  end

  // Address decode ignores the two byte-offset bits of the word address.
  assign req = avs_read_i | avs_write_i;
  assign hit_port = (avs_address_i[11:2] == 10'(`PSRB_PORT_OFS >> 2));
  assign hit_periph = (avs_address_i[11:2] == 10'(`PSRB_PERIPH_OFS >> 2));
  assign accept = req & ack_ff & ce_i;

  // An access takes one wait cycle while ce_i stays high; that cycle latches the read data so
  // the answer comes from a flop rather than from the decode path.
  always_comb
  begin
    nxt_ack = ack_ff;
    nxt_rdata = rdata_ff;
    if (ce_i)
    begin
      nxt_ack = req & ~ack_ff;
      if (avs_read_i && !ack_ff)
      begin
        if (hit_port)
        begin
          nxt_rdata = port_q;
        end
        else if (hit_periph)
        begin
          nxt_rdata = periph_q;
        end
        else
        begin
          nxt_rdata = 32'h0000_0000; // Unmapped reads answer zero.
        end
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_sync_ff)
  begin
    if (!rst_sync_ff)
    begin
      ack_ff <= 1'b0;
      rdata_ff <= 32'h0000_0000;
    end
    else
    begin
      ack_ff <= nxt_ack;
      rdata_ff <= nxt_rdata;
    end
  end

  // The answer is only given while ce_i is high; otherwise a master would see
  // the access finish in a cycle in which no register could take the write.
  assign avs_waitrequest_o = req & ~(ack_ff & ce_i);
  assign avs_readdata_o = rdata_ff;

  // Port register: the capability word masks absent ports out of a write.
  psrb_mask_reg #(
    .IMPL_MASK(`PSRB_PORT_IMPL),
    .RST_VAL(`PSRB_PORT_RST)
  ) u_port_reg (
    .clk_i(clk_i),
    .rst_n_i(rst_sync_ff),
    .ce_i(ce_i),
    .wr_i(accept & avs_write_i & hit_port),
    .wdata_i(avs_writedata_i),
    .be_i(avs_byteenable_i),
    .cap_i(capability_register_four_i),
    .q_o(port_q)
  );

  // Peripheral register: gated the same way by capability word two.
  psrb_mask_reg #(
    .IMPL_MASK(`PSRB_PERIPH_IMPL),
    .RST_VAL(`PSRB_PERIPH_RST)
  ) u_periph_reg (
    .clk_i(clk_i),
    .rst_n_i(rst_sync_ff),
    .ce_i(ce_i),
    .wr_i(accept & avs_write_i & hit_periph),
    .wdata_i(avs_writedata_i),
    .be_i(avs_byteenable_i),
    .cap_i(capability_register_two_i),
    .q_o(periph_q)
  );

  // Reset lines follow the register bits directly; a set bit keeps the
  // peripheral in reset until software clears it.
  assign port_rst_o = port_q[`PSRB_PORT_BITS-1:0];

  // One process fills the whole struct, so the output has a single driver.
  always_comb
  begin
    periph_rst_o.serial_port_zero_reset = periph_q[`PSRB_BIT_SERIAL0];
    periph_rst_o.serial_port_one_reset = periph_q[`PSRB_BIT_SERIAL1];
    periph_rst_o.sync_serial_unit_zero_reset = periph_q[`PSRB_BIT_SYNC0];
    periph_rst_o.two_wire_unit_zero_reset = periph_q[`PSRB_BIT_TWO_WIRE0];
    periph_rst_o.gp_counter_zero_reset = periph_q[`PSRB_BIT_GP0];
    periph_rst_o.gp_counter_one_reset = periph_q[`PSRB_BIT_GP1];
    periph_rst_o.gp_counter_two_reset = periph_q[`PSRB_BIT_GP2];
    periph_rst_o.gp_counter_three_reset = periph_q[`PSRB_BIT_GP3];
  end

  // Checks on the register bank and the bus answer.
  default clocking cb_main @(posedge clk_i);
  endclocking
  default disable iff (!rst_sync_ff);

  logic wr_port_acc;
  logic wr_periph_acc;
  assign wr_port_acc = accept & avs_write_i & hit_port;
  assign wr_periph_acc = accept & avs_write_i & hit_periph;

  property p_port_cap_gate;
    wr_port_acc |=> ((port_q ^ $past(port_q)) & ~$past(capability_register_four_i)) == 32'h0000_0000;
  endproperty
  a_port_cap_gate: assert property (p_port_cap_gate)
    else $error("Port reset bit changed without capability.");

  property p_port_full_write;
    wr_port_acc && capability_register_four_i == 32'hFFFF_FFFF && avs_byteenable_i[0]
      |=> port_q[7:0] == $past(avs_writedata_i[7:0]);
  endproperty
  a_port_full_write: assert property (p_port_full_write)
    else $error("Port reset field did not take the written value.");

  property p_port_reserved;
    port_q[31:8] == 24'h00_0000;
  endproperty
  a_port_reserved: assert property (p_port_reserved)
    else $error("Reserved port reset bits are not zero.");

  property p_periph_serial;
    wr_periph_acc && capability_register_two_i == 32'hFFFF_FFFF && avs_byteenable_i[0]
      |=> periph_q[4:0] == ($past(avs_writedata_i[4:0]) & 5'h13);
  endproperty
  a_periph_serial: assert property (p_periph_serial)
    else $error("Serial reset bits did not follow the write.");

  property p_periph_reserved;
    (periph_q[11:5] == 7'h00) && (periph_q[3:2] == 2'h0);
  endproperty
  a_periph_reserved: assert property (p_periph_reserved)
    else $error("Reserved peripheral reset bits are not zero.");

  property p_counter_bits;
    wr_periph_acc && capability_register_two_i == 32'hFFFF_FFFF && avs_byteenable_i[2]
      |=> periph_rst_o[7:4] == {$past(avs_writedata_i[19:16])} ;
  endproperty
  a_counter_bits: assert property (p_counter_bits)
    else $error("Counter reset lines did not follow the write.");

  property p_two_wire_bit;
    wr_periph_acc && capability_register_two_i == 32'hFFFF_FFFF && avs_byteenable_i[1]
      |=> periph_rst_o.two_wire_unit_zero_reset == $past(avs_writedata_i[12]);
  endproperty
  a_two_wire_bit: assert property (p_two_wire_bit)
    else $error("Two-wire reset line did not follow the write.");

  property p_periph_cap_gate;
    wr_periph_acc |=> ((periph_q ^ $past(periph_q)) & ~$past(capability_register_two_i)) == 32'h0000_0000;
  endproperty
  a_periph_cap_gate: assert property (p_periph_cap_gate)
    else $error("Peripheral reset bit changed without capability.");

  property p_hold_without_write;
    !wr_port_acc && !wr_periph_acc |=> $stable(port_rst_o) && $stable(periph_rst_o);
  endproperty
  a_hold_without_write: assert property (p_hold_without_write)
    else $error("Reset line moved without a register write.");

  property p_bus_answer;
    req && ce_i && !ack_ff ##1 ce_i |-> !avs_waitrequest_o || !req;
  endproperty
  a_bus_answer: assert property (p_bus_answer)
    else $error("Bus access not answered after one wait cycle.");

  property p_stall_holds_wait;
    req && !ce_i |-> avs_waitrequest_o;
  endproperty
  a_stall_holds_wait: assert property (p_stall_holds_wait)
    else $error("Bus answered while the clock enable was low.");

endmodule : psrb_top

`default_nettype wire

// ---- inc/psrb_cfg.svh ----
/*
  Constants of the peripheral soft reset bank: offsets, field positions,
  implemented-bit masks and reset values.
  Assumes it is included by bare name from the package and design files.
*/
`ifndef PSRB_CFG_SVH
`define PSRB_CFG_SVH

// Byte offsets of the two registers on the register bus.
`define PSRB_PERIPH_OFS 12'h044
`define PSRB_PORT_OFS 12'h048

// Reset values of both registers.
`define PSRB_PERIPH_RST 32'h0000_0000
`define PSRB_PORT_RST 32'h0000_0000

// Bits that exist in each register; every other bit reads as zero.
`define PSRB_PERIPH_IMPL 32'h000F_1013
`define PSRB_PORT_IMPL 32'h0000_00FF

// Field positions in the peripheral reset register.
`define PSRB_BIT_SERIAL0 0
`define PSRB_BIT_SERIAL1 1
`define PSRB_BIT_SYNC0 4
`define PSRB_BIT_TWO_WIRE0 12
`define PSRB_BIT_GP0 16
`define PSRB_BIT_GP1 17
`define PSRB_BIT_GP2 18
`define PSRB_BIT_GP3 19

// Width of the port reset field.
`define PSRB_PORT_BITS 8

`endif

// ---- inc/psrb_pkg.sv ----
/*
  Types shared by the peripheral soft reset bank.
  Assumes psrb_cfg.svh is on the include path.
*/
`default_nettype none
`include "psrb_cfg.svh"

package psrb_pkg;

  // One reset line per general-purpose I/O port.
  typedef struct packed {
    logic port_h_reset;
    logic port_g_reset;
    logic port_f_reset;
    logic port_e_reset;
    logic port_d_reset;
    logic port_c_reset;
    logic port_b_reset;
    logic port_a_reset;
  } psrb_port_rst_s;

  // One reset line per serial, two-wire and counter peripheral.
  typedef struct packed {
    logic gp_counter_three_reset;
    logic gp_counter_two_reset;
    logic gp_counter_one_reset;
    logic gp_counter_zero_reset;
    logic two_wire_unit_zero_reset;
    logic sync_serial_unit_zero_reset;
    logic serial_port_one_reset;
    logic serial_port_zero_reset;
  } psrb_periph_rst_s;

  typedef logic [31:0] psrb_word_t;

  // Expands the four byte enables into a bit mask.
  function automatic psrb_word_t psrb_be_mask(input logic [3:0] be);
    psrb_word_t m;
    m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
    return m;
  endfunction : psrb_be_mask

endpackage : psrb_pkg

`default_nettype wire

// ---- core/psrb_mask_reg.sv ----
/*
  One 32-bit control register whose writes are gated by a capability word,
  by byte enables and by the set of bits that exist.
  Assumes an active-low reset whose release is already synchronised to clk_i.
*/
`default_nettype none
`include "psrb_cfg.svh"

module psrb_mask_reg #(
  parameter logic [31:0] IMPL_MASK = 32'h0000_0000,
  parameter logic [31:0] RST_VAL = 32'h0000_0000
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  input wire logic wr_i,
  input wire logic [31:0] wdata_i,
  input wire logic [3:0] be_i,
  input wire logic [31:0] cap_i,
  output logic [31:0] q_o
);

  logic [31:0] q_ff;
  logic [31:0] nxt_q;
  logic [31:0] wmask;

  // Only bits that exist, are enabled by byte lane and are present per
  // capability change; absent peripherals therefore keep reading zero.
  always_comb
  begin
    wmask = psrb_pkg::psrb_be_mask(be_i) & cap_i & IMPL_MASK;
    nxt_q = q_ff;
    if (ce_i && wr_i)
    begin
      nxt_q = (q_ff & ~wmask) | (wdata_i & wmask);
    end
  end

  // Register stage; reserved bits can never become one.
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      q_ff <= RST_VAL;
    end
    else
    begin
      q_ff <= nxt_q & IMPL_MASK;
    end
  end

  assign q_o = q_ff;

endmodule : psrb_mask_reg

`default_nettype wire

// ---- dv/psrb_test.sv ----
/*
  Self-checking bench for the peripheral soft reset bank: register access,
  capability gating, byte lanes, reserved bits, clock-enable stalls and resets.
  Assumes psrb_cfg.svh and psrb_pkg are compiled before this file.
*/
`default_nettype none
`include "psrb_cfg.svh"

// Counts every comparison and reports a mismatch at once.
`define CHK(got, exp) \
  begin \
    compares++; \
    if ((got) !== (exp)) \
    begin \
      n_fail++; \
      $display("ERROR t=%0t got %h exp %h", $time, got, exp); \
    end \
  end

module psrb_test;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [31:0] PER_BITS = 32'h000F_1013;
  localparam logic [31:0] PORT_BITS = 32'h0000_00FF;
  localparam logic [11:0] PER = 12'h044;
  localparam logic [11:0] PORT = 12'h048;
  logic clk, rst_n, ce, rd_en, wr_en, busy;
  logic [11:0] addr, ra;
  logic [31:0] wdata, rdata, cap2, cap4, exp_per, exp_port, lfsr_q, rv;
  logic [3:0] be;
  psrb_pkg::psrb_port_rst_s port_rst;
  psrb_pkg::psrb_periph_rst_s periph_rst;
  int n_fail, compares;

  psrb_top psrb_top_inst (
    .clk_i(clk), .rst_n_i(rst_n), .ce_i(ce), .avs_address_i(addr),
    .avs_read_i(rd_en), .avs_write_i(wr_en), .avs_writedata_i(wdata),
    .avs_byteenable_i(be), .avs_readdata_o(rdata), .avs_waitrequest_o(busy),
    .capability_register_two_i(cap2), .capability_register_four_i(cap4),
    .port_rst_o(port_rst), .periph_rst_o(periph_rst)
  );

  // Free-running 125 MHz clock.
  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // Advances the fixed-seed shift register; one bit per call keeps it cheap.
  function automatic logic [31:0] rnd();
    lfsr_q = {lfsr_q[30:0], lfsr_q[31] ^ lfsr_q[21] ^ lfsr_q[1] ^ lfsr_q[0]};
    return lfsr_q;
  endfunction : rnd

  // Only bits that exist, are enabled by capability and by byte lane change.
  function automatic logic [31:0] merge(input logic [31:0] old, d, gate, impl,
                                        input logic [3:0] b);
    logic [31:0] m;
    m = gate & impl & {{8{b[3]}}, {8{b[2]}}, {8{b[1]}}, {8{b[0]}}};
    return (old & ~m) | (d & m);
  endfunction : merge

  // Expected read data; the two low address bits do not take part in decode.
  function automatic logic [31:0] reg_val(input logic [11:0] a);
    if (a[11:2] == PER[11:2])
      return exp_per;
    if (a[11:2] == PORT[11:2])
      return exp_port;
    return 32'h0000_0000;
  endfunction : reg_val

  // Starts just after a rising edge, ends at the accepting edge, request still up.
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d,
                     input logic [3:0] b, input int st);
    int n;
    n = 0;
    addr <= a;
    wr_en <= w;
    rd_en <= !w;
    wdata <= d;
    be <= b;
    ce <= (st == 0);
    // At a rising edge the bench sees what the design showed just before it.
    repeat (st)
    begin
      @(posedge clk);
      `CHK(busy, 1'b1)
    end
    if (st > 0)
    begin
      ce <= 1'b1;
    end
    do
    begin
      @(posedge clk);
      n++;
    end
    while (busy !== 1'b0 && n < 40);
    `CHK(busy, 1'b0)
    rv = rdata;
  endtask : bus

  // One access with its model update or read comparison.
  task automatic op(input logic w, input logic [11:0] a, input logic [31:0] d,
                    input logic [3:0] b, input int st);
    bus(w, a, d, b, st);
    if (!w)
      `CHK(rv, reg_val(a))
    else if (a[11:2] == PER[11:2])
      exp_per = merge(exp_per, d, cap2, PER_BITS, b);
    else if (a[11:2] == PORT[11:2])
      exp_port = merge(exp_port, d, cap4, PORT_BITS, b);
  endtask : op

  // Releases the bus and checks the reset lines once they have settled.
  task automatic idle();
    rd_en <= 1'b0;
    wr_en <= 1'b0;
    @(negedge clk);
    @(negedge clk);
    `CHK(port_rst, exp_port[7:0])
    `CHK(periph_rst, {exp_per[19:16], exp_per[12], exp_per[4], exp_per[1:0]})
    @(posedge clk);
  endtask : idle

  task automatic stop_test();
    $display("compares=%0d n_fail=%0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : stop_test

  // The whole run needs about 1500 cycles; this cuts a hang short.
  initial
  begin
    repeat (30000) @(posedge clk);
    n_fail++;
    stop_test();
  end

  // Reset values, walking ones, gating corners, random traffic, mid-run reset.
  initial
  begin
    rst_n = 1'b0;
    ce = 1'b1;
    {rd_en, wr_en, addr, wdata, be} = '0;
    cap2 = '1;
    cap4 = '1;
    {exp_per, exp_port} = '0;
    lfsr_q = 32'hffc5_1835;
    n_fail = 0;
    compares = 0;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    op(1'b0, PER, '0, 4'h0, 0);
    op(1'b0, PORT, '0, 4'h0, 0);
    idle();
    for (int i = 0; i < 32; i++)
    begin
      op(1'b1, PER, 32'h1 << i, 4'hF, 0);
      op(1'b0, PER, '0, 4'h0, 0);
      op(1'b1, PORT, 32'h1 << i, 4'hF, 0);
      op(1'b0, PORT, '0, 4'h0, 0);
      idle();
    end
    // With both capability words clear nothing may change.
    op(1'b1, PER, '1, 4'hF, 0);
    op(1'b1, PORT, '1, 4'hF, 0);
    cap2 <= '0;
    cap4 <= '0;
    op(1'b1, PER, '0, 4'hF, 1);
    op(1'b1, PORT, '0, 4'hF, 0);
    op(1'b0, PER, '0, 4'h0, 0);
    op(1'b0, PORT, '0, 4'h0, 2);
    idle();
    repeat (300)
    begin
      cap2 <= rnd();
      cap4 <= rnd();
      rv = rnd();
      ra = {(rv[1:0] == 2'd0) ? PER[11:2] : (rv[1:0] == 2'd1) ? PORT[11:2] : rv[15:6],
            rv[5:4]};
      op(rv[8], ra, rnd(), rv[12:9], int'(rv[17:16]) % 3);
      if (lfsr_q[20])
        idle();
    end
    idle();
    // A second reset clears both registers and drops every reset line.
    cap2 <= '1;
    cap4 <= '1;
    op(1'b1, PER, '1, 4'hF, 0);
    op(1'b1, PORT, '1, 4'hF, 0);
    idle();
    rst_n <= 1'b0;
    {exp_per, exp_port} = '0;
    idle();
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    op(1'b0, PER, '0, 4'h0, 0);
    op(1'b0, PORT, '0, 4'h0, 0);
    idle();
    stop_test();
  end
endmodule : psrb_test

`default_nettype wire
